// ### design/dcm_top.sv
/*
  Calibration-mode logic of a DDR3-class memory: write-leveling
  feedback with its ordered exit, and the calibration pattern
  register readout. Assumes a controller that keeps its own command
  rules, a link clock far slower than clk, and an APB master.
*/
// Overview of operation
// - Mode register one bit seven toggles leveling
// - Leveling: ODT switches strobe termination only
// - Feedback on prime bit, rest low or copy
// - After exit, DQ undefined until update delay
// - Mode register three bit two enables readout
// - Enabled readout serves every read from register
// - Autoprecharge read acts as plain read
// - Reset still works while readout enabled
// - Bit zero per lane, rest copy or zero
// - Chopped burst order follows address bit two
// - Bank and upper column bits ignored
// - A12 picks chop when on-the-fly enabled
// - Burst after additive plus CAS latency
// - Location zero gives alternating zero one
// - Burst order zero maps to LSB
`timescale 1ns/1ps
module dcm_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ck,
  input wire logic dram_rst_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [dcm_pkg::BA_W-1:0] ba,
  input wire logic [dcm_pkg::ADDR_W-1:0] addr,
  input wire logic odt,
  input wire logic [1:0] dqs_i,
  output logic [1:0] dqs_o,
  output logic dqs_oe,
  input wire logic [dcm_pkg::DQ_W-1:0] dq_i,
  output logic [dcm_pkg::DQ_W-1:0] dq_o,
  output logic dq_oe,
  output logic dqs_term_on,
  output logic dq_term_on,
  output logic arr_rd,
  output logic arr_ap
);
  import dcm_pkg::*;
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic ck_p;              // Link clock, last sample
    logic [1:0] dqs_p;       // Strobes, last sample
    logic [1:0] mr0_bl;      // Burst length field
    logic wl;                // Leveling active
    logic calib_pattern_register;               // Calibration readout active
    logic [1:0] loc;         // Location select
    logic [1:0] fb;          // Per-lane sampled clock
    logic [4:0] mod_cnt;     // Exit settle count
    logic bad;               // Forbidden command seen
    logic [15:0] ctrl;       // Control register
    logic [31:0] rdata;      // APB read data
    logic [PIPE_D-1:0][2:0] pipe; // Read latency line
    logic arr_rd;            // Array read request
    logic arr_ap;            // Array autoprecharge
    logic [DQ_W-1:0] dq;     // DQ drive value
    logic dq_oe;             // DQ enable
    logic [1:0] dqs;         // Read strobe value
    logic dqs_oe;            // Read strobe enable
    logic dqs_term;          // Strobe termination
    logic dq_term;           // DQ termination
  } dcm_st_t;
  dcm_st_t st_q, st_d;
  // Synchronised pins
  logic [SYNC_W-1:0] pins_s;
  logic rst_s, ck_s, odt_s, cs_s, ras_s, cas_s, we_s;
  logic [1:0] dqs_s;
  logic [BA_W-1:0] ba_s;
  logic [ADDR_W-1:0] a_s;
  // Burst carrier
  dcm_burst_if bi();
  // DQ input is not used in these modes; write data lives elsewhere
  logic unused_dq;
  assign unused_dq = ^dq_i;
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // The link clock is 16x slower, so a command sampled at the synced
  // ck rise has long settled on every bit
  dcm_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din({dram_rst_n, ck, odt, dqs_i, cs_n, ras_n, cas_n, we_n, ba, addr}),
    .dout(pins_s)
  );
  assign {rst_s, ck_s, odt_s, dqs_s, cs_s, ras_s, cas_s, we_s, ba_s, a_s} = pins_s;
  // ----------------------------------------
  // Burst generator
  // ----------------------------------------
  dcm_burst u_burst (
    .clk(clk),
    .arst_n(arst_n),
    .bi(bi)
  );
  // Command match on a sampled command, deselect never matches
  function automatic logic is_cmd(input logic [2:0] code);
    return !cs_s && ({ras_s, cas_s, we_s} == code);
  endfunction
  // Register decode shared by read and write
  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction
  // Combinational helpers
  logic ck_rise, ck_edge, rd_cmd, mrs_cmd, bc4, cal_ok, stat_clr;
  logic [4:0] rl;
  logic [4:0] tap;
  logic [2:0] slot;
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    ck_rise = ck_s && !st_q.ck_p;
    ck_edge = ck_s != st_q.ck_p;
    rd_cmd = is_cmd(CMD_RD);
    mrs_cmd = is_cmd(CMD_MRS);
    stat_clr = 1'b0;
    st_d.ck_p = ck_s;
    st_d.dqs_p = dqs_s;
    st_d.arr_rd = 1'b0;
    st_d.arr_ap = 1'b0;
    // Read latency in link cycles, at least one
    rl = 5'(st_q.ctrl[CTRL_CL_LSB +: 4]) + 5'(st_q.ctrl[CTRL_AL_LSB +: 4]);
    tap = (rl == 5'h0) ? 5'h0 : rl - 5'h1;
    slot = st_q.pipe[tap];
    // Chop choice: on the fly from A12, else fixed by mode
    if (st_q.mr0_bl == BL_OTF) begin
      bc4 = !a_s[BC_BIT];
    end else begin
      bc4 = st_q.mr0_bl == BL_BC4;
    end
    // Allowed while the readout is on: reads, idle, disabling write
    cal_ok = rd_cmd || cs_s || is_cmd(CMD_NOP) ||
             (mrs_cmd && ba_s == MR_THREE && !a_s[CAL_EN_BIT]);
    // Leveling feedback: each lane samples ck on its own strobe rise
    for (int l = 0; l < 2; l++) begin
      if (st_q.wl && dqs_s[l] && !st_q.dqs_p[l]) begin
        st_d.fb[l] = ck_s;
      end
    end
    // Link commands, taken at the link clock rise
    if (ck_rise) begin
      st_d.pipe = {st_q.pipe[PIPE_D-2:0], 3'h0};
      if (st_q.mod_cnt != 5'h0) begin
        st_d.mod_cnt = st_q.mod_cnt - 5'h1;
      end
      if (st_q.calib_pattern_register && !cal_ok) begin
        st_d.bad = 1'b1;
      end
      if (mrs_cmd) begin
        unique case (ba_s)
          MR_ZERO: begin
            st_d.mr0_bl = a_s[1:0];
          end
          MR_ONE: begin
            st_d.wl = a_s[WL_BIT];
            if (st_q.wl && !a_s[WL_BIT]) begin
              // DQ stay undefined (released) until the settle expires
              st_d.mod_cnt = MOD_NCK;
              st_d.fb = 2'h0;
            end
          end
          MR_THREE: begin
            st_d.calib_pattern_register = a_s[CAL_EN_BIT];
            st_d.loc = a_s[1:0];
          end
          default: begin
          end
        endcase
      end else if (rd_cmd && st_q.calib_pattern_register) begin
        // Bank, A10, A11, A13 and A9..A3 play no part here
        st_d.pipe[0] = {1'b1, bc4, bc4 && a_s[ORDER_BIT]};
      end else if (rd_cmd) begin
        st_d.arr_rd = 1'b1;
        st_d.arr_ap = a_s[AP_BIT];
      end
    end
    // Device reset clears modes even with the readout on
    if (!rst_s) begin
      st_d.wl = 1'b0;
      st_d.calib_pattern_register = 1'b0;
      st_d.loc = 2'h0;
      st_d.fb = 2'h0;
      st_d.mod_cnt = 5'h0;
      st_d.pipe = '0;
    end
    // Termination: in leveling ODT reaches only the strobes
    st_d.dqs_term = odt_s;
    st_d.dq_term = odt_s && !st_q.wl;
    // Output drive
    st_d.dq = '0;
    st_d.dq_oe = 1'b0;
    st_d.dqs = 2'h0;
    st_d.dqs_oe = 1'b0;
    if (!rst_s || st_q.mod_cnt != 5'h0) begin
      // Released: undefined window or device reset
    end else if (st_q.wl) begin
      st_d.dq_oe = 1'b1;
      for (int l = 0; l < 2; l++) begin
        if (st_q.ctrl[CTRL_FB_ALL]) begin
          st_d.dq[8*l +: 8] = {8{st_q.fb[l]}};
        end else begin
          st_d.dq[8*l +: 8] = {7'h0, st_q.fb[l]};
        end
      end
    end else if (bi.busy) begin
      st_d.dq_oe = 1'b1;
      st_d.dqs_oe = 1'b1;
      st_d.dqs = {2{!bi.beat_odd}};
      for (int l = 0; l < 2; l++) begin
        if (st_q.ctrl[CTRL_LANE_COPY]) begin
          st_d.dq[8*l +: 8] = {8{bi.bit_out}};
        end else begin
          st_d.dq[8*l +: 8] = {7'h0, bi.bit_out};
        end
      end
    end
    // APB write in the access phase
    if (psel && penable && pwrite) begin
      if (reg_hit(paddr, ADDR_CTRL)) begin
        st_d.ctrl = pwdata[15:0];
      end
      if (reg_hit(paddr, ADDR_STAT)) begin
        stat_clr = pwdata[STAT_BAD];
      end
    end
    // A forbidden command in the clearing cycle still sets the flag
    st_d.bad = (st_q.bad && !stat_clr) || (ck_rise && st_q.calib_pattern_register && !cal_ok);
    // APB read data captured in the setup phase
    if (psel && !penable) begin
      st_d.rdata = '0;
      if (reg_hit(paddr, ADDR_CTRL)) begin
        st_d.rdata[15:0] = st_q.ctrl;
      end else if (reg_hit(paddr, ADDR_STAT)) begin
        st_d.rdata[STAT_WL] = st_q.wl;
        st_d.rdata[STAT_MPR] = st_q.calib_pattern_register;
        st_d.rdata[STAT_LOC_LSB +: 2] = st_q.loc;
        st_d.rdata[STAT_UNDEF] = st_q.mod_cnt != 5'h0;
        st_d.rdata[STAT_BUSY] = bi.busy;
        st_d.rdata[STAT_BAD] = st_q.bad;
      end
    end
  end
  // ----------------------------------------
  // Burst launch
  // ----------------------------------------
  always_comb begin
    bi.start = ck_rise && slot[2] && rst_s;
    bi.bc4 = slot[1];
    bi.hi = slot[0];
    bi.edge_ev = ck_edge;
    // Reserved locations return a fixed filler
    bi.pattern = (st_q.loc == 2'h0) ? LOC0_PATTERN : RFU_PATTERN;
  end
  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
      st_q.ctrl <= CTRL_RESET;
    end else begin
      st_q <= st_d;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = st_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr, ADDR_CTRL) && !reg_hit(paddr, ADDR_STAT);
  assign dq_o = st_q.dq;
  assign dq_oe = st_q.dq_oe;
  assign dqs_o = st_q.dqs;
  assign dqs_oe = st_q.dqs_oe;
  assign dqs_term_on = st_q.dqs_term;
  assign dq_term_on = st_q.dq_term;
  assign arr_rd = st_q.arr_rd;
  assign arr_ap = st_q.arr_ap;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  dq_term_off_a: assert property ($past(st_q.wl) |-> !dq_term_on)
    else $error("DQ termination on during leveling");
  prime_low_a: assert property (dq_oe && $past(st_q.wl) && !$past(st_q.ctrl[CTRL_FB_ALL])
    |-> dq_o[7:1] == 7'h0 && dq_o[15:9] == 7'h0)
    else $error("Non-prime DQ not low in leveling");
  exit_undef_a: assert property ($fell(st_q.wl) && rst_s |=> !dq_oe [*8])
    else $error("DQ driven right after leveling exit");
  no_array_a: assert property (arr_rd |-> !$past(st_q.calib_pattern_register))
    else $error("Array read while readout enabled");
  no_precharge_a: assert property (arr_ap |-> arr_rd && !$past(st_q.calib_pattern_register))
    else $error("Autoprecharge in readout mode");
  reset_clear_a: assert property (!rst_s |=> !st_q.calib_pattern_register && !st_q.wl)
    else $error("Device reset ignored");
  lane_zero_a: assert property (dq_oe && $past(bi.busy) && !$past(st_q.wl)
    && !$past(st_q.ctrl[CTRL_LANE_COPY]) |-> dq_o[0] == dq_o[8] && dq_o[7:1] == 7'h0)
    else $error("Lane bits not zero");
  chop_hi_a: assert property (bi.start && bi.hi |=> bi.bit_out == $past(bi.pattern[4]))
    else $error("Upper nibble order wrong");
  loc0_pat_a: assert property (bi.start && st_q.loc == 2'h0 |-> bi.pattern == 8'hAA ##1 (bi.busy && !bi.bit_out))
    else $error("Location zero pattern wrong");
  lsb_first_a: assert property (bi.start && !bi.hi |=> bi.bit_out == $past(bi.pattern[0]))
    else $error("Burst bit zero not LSB");
  wl_fb_c: cover property ($rose(st_q.fb[0]) && st_q.wl);
  bc4_hi_c: cover property (bi.start && bi.bc4 && bi.hi);
  bl8_c: cover property (bi.start && !bi.bc4);
  bad_c: cover property ($rose(st_q.bad));
endmodule

// ### shared/dcm_pkg.sv
/*
  Constants for the DRAM calibration-mode block: register map, field
  positions, reset values, command codes and link-side counts.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dcm_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 14;
  localparam int BA_W = 3;
  localparam int DQ_W = 16;
  localparam int SYNC_W = 26;
  localparam int PIPE_D = 32;
  // ----------------------------------------
  // APB register map
  // ----------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam int CTRL_FB_ALL = 0;
  localparam int CTRL_LANE_COPY = 1;
  localparam int CTRL_CL_LSB = 4;
  localparam int CTRL_AL_LSB = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0060;
  localparam int STAT_WL = 0;
  localparam int STAT_MPR = 1;
  localparam int STAT_LOC_LSB = 2;
  localparam int STAT_UNDEF = 4;
  localparam int STAT_BUSY = 5;
  localparam int STAT_BAD = 8;
  // ----------------------------------------
  // Link commands {ras_n, cas_n, we_n}
  // ----------------------------------------
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // ----------------------------------------
  // Mode register selects and bits
  // ----------------------------------------
  localparam logic [2:0] MR_ZERO = 3'h0;
  localparam logic [2:0] MR_ONE = 3'h1;
  localparam logic [2:0] MR_THREE = 3'h3;
  localparam int WL_BIT = 7;
  localparam int CAL_EN_BIT = 2;
  localparam int BC_BIT = 12;
  localparam int AP_BIT = 10;
  localparam int ORDER_BIT = 2;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_BC4 = 2'h2;
  // ----------------------------------------
  // Calibration data and link counts
  // ----------------------------------------
  localparam logic [7:0] LOC0_PATTERN = 8'hAA;
  localparam logic [7:0] RFU_PATTERN = 8'h00;
  localparam logic [4:0] MOD_NCK = 5'h0C;
endpackage

// ### shared/dcm_burst_if.sv
/*
  Carrier between the calibration control logic and its burst
  generator. Assumes both ends run on the same clk.
*/
`timescale 1ns/1ps
interface dcm_burst_if;
  logic start;         // Begin a burst, one-cycle pulse
  logic bc4;           // Four-beat chop
  logic hi;            // Start at beat four
  logic edge_ev;       // Any link clock edge
  logic [7:0] pattern; // Selected location content
  logic bit_out;       // Current beat bit
  logic beat_odd;      // Current beat is odd
  logic busy;          // Burst in progress
  modport ctl(output start, bc4, hi, edge_ev, pattern,
              input bit_out, beat_odd, busy);
  modport gen(input start, bc4, hi, edge_ev, pattern,
              output bit_out, beat_odd, busy);
endinterface

// ### design/dcm_sync.sv
/*
  Two-stage synchroniser for pins entering the clk domain.
  Assumes each bus is quasi-static around the edge that samples it.
*/
`timescale 1ns/1ps
module dcm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import dcm_pkg::*;
  typedef struct packed {
    logic [W-1:0] s1; // First stage, read only by s2
    logic [W-1:0] s2; // Settled copy
  } dcm_sync_st_t;
  dcm_sync_st_t st_q, st_d;
  // Next stage values
  always_comb begin
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end
  // Stage registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign dout = st_q.s2;
endmodule

// ### design/dcm_burst.sv
/*
  Calibration burst generator: walks the location bits one beat per
  link clock edge. Assumes edge_ev marks both link clock edges.
*/
`timescale 1ns/1ps
module dcm_burst (
  input wire logic clk,
  input wire logic arst_n,
  dcm_burst_if.gen bi
);
  import dcm_pkg::*;
  typedef struct packed {
    logic busy;      // Beats remain
    logic [2:0] idx; // Burst order index
    logic [3:0] left; // Beats left
    logic [7:0] data; // Latched location
    logic bit_v;     // Bit on the wire
  } dcm_burst_st_t;
  dcm_burst_st_t st_q, st_d;
  // ----------------------------------------
  // Beat sequencing
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    if (bi.start) begin
      // A new start reloads, so back-to-back reads stay seamless
      st_d.busy = 1'b1;
      st_d.idx = bi.hi ? 3'h4 : 3'h0;
      st_d.left = bi.bc4 ? 4'h4 : 4'h8;
      st_d.data = bi.pattern;
      st_d.bit_v = bi.hi ? bi.pattern[4] : bi.pattern[0];
    end else if (bi.edge_ev && st_q.busy) begin
      // Next beat, or finish after the last one
      st_d.left = st_q.left - 4'h1;
      st_d.idx = st_q.idx + 3'h1;
      st_d.bit_v = st_q.data[st_d.idx];
      if (st_q.left == 4'h1) begin
        st_d.busy = 1'b0;
      end
    end
  end
  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign bi.busy = st_q.busy;
  assign bi.bit_out = st_q.bit_v;
  assign bi.beat_odd = st_q.idx[0];
endmodule

// ### tb/dcm_ctl_model.sv
/*
  Memory controller model for the calibration-mode block: link clock,
  command pins, termination request, strobes and device reset pin.
  Assumes clk is the sampling clock of the block it faces.
*/
`timescale 1ns/1ps
module dcm_ctl_model
  import dcm_pkg::*;
(
  input wire logic clk,
  output logic ck,
  output logic dram_rst_n,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [BA_W-1:0] ba,
  output logic [ADDR_W-1:0] addr,
  output logic odt,
  output logic [1:0] dqs_i,
  output logic [DQ_W-1:0] dq_i
);
  time t_cmd; // Link edge that took the last command
  logic lvl;  // Link clock level at the last strobe rise
  // ----------------------------------------
  // Pin defaults and link clock
  // ----------------------------------------
  // Clock runs free from time zero, so the loop is long locked before reads
  initial begin
    {cs_n, ras_n, cas_n, we_n, odt} = 5'h1E;
    {dram_rst_n, dqs_i, ba, addr} = {1'b1, 2'h0, 3'h5, 14'h2AAA};
    dq_i = 16'h5A5A;
    ck = 1'b0;
    #3;
    forever #80 ck = ~ck;
  end
  // Data lines are never read by the block here; keep them moving, not stale
  always @(posedge clk) dq_i <= ~dq_i;
  // ----------------------------------------
  // Command and mode-register tasks
  // ----------------------------------------
  // Held over one whole link period around the taking edge
  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
    @(negedge ck);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= {1'b0, c};
    {ba, addr} <= {b, a};
    @(posedge ck);
    t_cmd = $time;
    @(negedge ck);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= {1'b1, CMD_NOP};
    {ba, addr} <= {~b, ~a};
  endtask
  // Mode write, then the update delay before anything else
  task automatic mrs(input logic [2:0] b, input logic [13:0] a);
    cmd(CMD_MRS, b, a);
    repeat (MOD_NCK) @(posedge ck);
  endtask
  // One leveling pulse; widths of eight clk clear the minimum
  task automatic strobe(input int phase);
    @(posedge ck);
    repeat (phase) @(posedge clk);
    dqs_i <= 2'h3;
    lvl = ck;
    repeat (8) @(posedge clk);
    dqs_i <= 2'h0; // Strobes stop after the last rise
    repeat (8) @(posedge clk);
  endtask
  // Termination request, lowered before leaving leveling
  task automatic set_odt(input logic v);
    @(posedge clk);
    odt <= v;
  endtask
  // Device reset pulse
  task automatic pulse_rst();
    @(posedge clk);
    dram_rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    dram_rst_n <= 1'b1;
  endtask
endmodule

// ### tb/tb_dram_calibration_modes.sv
/*
  Self-checking bench for the calibration-mode block: APB master,
  controller model, expected bursts from a queue model.
  Assumes the block answers APB with no wait states.
*/
`timescale 1ns/1ps
module tb_dram_calibration_modes;
  import dcm_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, ck, dram_rst_n;
  logic cs_n, ras_n, cas_n, we_n, odt, dqs_oe, dq_oe, dqs_term_on, dq_term_on;
  logic arr_rd, arr_ap, last_ap, errv, lane_copy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [1:0] dqs_i, dqs_o;
  logic [DQ_W-1:0] dq_i, dq_o;
  logic [7:0] ln;
  int mismatches, n_compared, n_arr, cycles, rl;
  // ----------------------------------------
  // Clock, model and block
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dcm_ctl_model m (.clk(clk), .ck(ck), .dram_rst_n(dram_rst_n), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
    .dqs_i(dqs_i), .dq_i(dq_i));
  dcm_top dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ck(ck), .dram_rst_n(dram_rst_n),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .odt(odt), .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_term_on(dqs_term_on),
    .dq_term_on(dq_term_on), .arr_rd(arr_rd), .arr_ap(arr_ap));
  // Array read counter and cycle ceiling; a hang ends as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (arr_rd === 1'b1) begin
      n_arr <= n_arr + 1;
      last_ap <= arr_ap;
    end
    if (cycles == 40000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Calibration read; expectation from the location content and order
  task automatic mpr_burst(input int loc, input bit bc4, input bit hi);
    logic [13:0] a;
    logic [7:0] pat;
    bit q[$];
    int n;
    a = 14'($urandom) & 14'h2BF8; // Ignored bits random, A[1:0] zero
    a[BC_BIT] = !bc4 || (loc == 3); // Fixed chop on the last location ignores A12
    a[AP_BIT] = !hi; // Autoprecharge reads must act as plain reads
    a[ORDER_BIT] = hi;
    pat = (loc == 0) ? 8'hAA : RFU_PATTERN;
    for (int i = 0; i < (bc4 ? 4 : 8); i++) q.push_back(pat[i + (hi ? 4 : 0)]);
    n = n_arr;
    m.cmd(CMD_RD, 3'($urandom), a);
    while (dq_oe !== 1'b1) @(posedge clk);
    #1;
    check(32'(($time - m.t_cmd) / 160), 32'(rl)); // Read latency
    repeat (4) @(posedge clk);
    foreach (q[i]) begin
      ln = lane_copy ? {8{q[i]}} : {7'h0, q[i]};
      // Strobe pair high on even beats, low on odd ones
      rdv = 32'({1'b1, (i % 2) ? 2'h0 : 2'h3, ln, ln});
      check(32'({dqs_oe, dqs_o, dq_o}), rdv);
      repeat (8) @(posedge clk);
    end
    check(32'({n_arr[30:0], dq_oe}), 32'({n[30:0], 1'b0})); // No array read, burst over
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {mismatches, n_compared, n_arr, cycles} = '0;
    void'($urandom(32'h822e));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rdv, 32'h60); // Control default
    apb(1'b0, 12'h0FC, 32'h0);
    check(32'(errv), 32'h1); // Unmapped address refused
    m.mrs(MR_ZERO, 14'h0001);
    m.cmd(CMD_RD, 3'h2, 14'h0400);
    repeat (8) @(posedge clk);
    check(32'({n_arr[1:0], last_ap}), 32'h3); // Array read outside readout
    for (int loc = 0; loc < 4; loc++) begin
      lane_copy = 1'($urandom);
      rl = 4 + loc + loc % 2;
      apb(1'b1, ADDR_CTRL, 32'(((loc % 2) << 8) | ((4 + loc) << 4) | (lane_copy << 1)));
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(rdv, 32'(((loc % 2) << 8) | ((4 + loc) << 4) | (lane_copy << 1)));
      m.mrs(MR_ZERO, (loc == 3) ? 14'h0002 : 14'h0001); // Fixed chop on the last location
      m.cmd(3'h2, 3'h0, 14'h0400); // Precharge all first
      m.mrs(MR_THREE, 14'(4 + loc));
      apb(1'b0, ADDR_STAT, 32'h0);
      check(rdv & 32'h10E, 32'(2 + 4 * loc)); // Readout on, location
      for (int k = 0; k < 3; k++) mpr_burst(loc, k > 0 || loc == 3, k == 2);
      if (loc < 3) begin
        repeat (4) @(posedge ck);
        m.mrs(MR_THREE, 14'h0000);
      end
    end
    m.cmd(3'h4, 3'h0, 14'h0000);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(32'(rdv[8]), 32'h1); // Write refused in readout
    apb(1'b1, ADDR_STAT, 32'h100);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(32'(rdv[8]), 32'h0); // Flag cleared
    m.pulse_rst();
    repeat (6) @(posedge clk);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rdv & 32'h10E, 32'h0); // Device reset leaves readout
    for (int fb = 0; fb < 2; fb++) begin
      apb(1'b1, ADDR_CTRL, 32'h60 | 32'(fb));
      m.mrs(MR_ONE, 14'h0080);
      m.set_odt(1'b1);
      repeat (6) @(posedge clk);
      check(32'({dqs_term_on, dq_term_on}), 32'h2); // Strobe termination only
      for (int ph = 4; ph <= 12; ph += 8) begin
        m.strobe(ph);
        ln = fb ? {8{m.lvl}} : {7'h0, m.lvl};
        check(32'({dq_oe, dq_o}), 32'({1'b1, ln, ln})); // Feedback
      end
      m.set_odt(1'b0);
      repeat (6) @(posedge clk);
      check(32'(dqs_term_on), 32'h0); // Termination off before exit
      m.cmd(CMD_MRS, MR_ONE, 14'h0000);
      repeat (4) @(posedge clk);
      apb(1'b0, ADDR_STAT, 32'h0);
      check(32'({dq_oe, rdv[STAT_UNDEF], rdv[STAT_WL]}), 32'h2); // Exit window
      repeat (13) @(posedge ck);
      apb(1'b0, ADDR_STAT, 32'h0);
      check(32'(rdv[STAT_UNDEF]), 32'h0); // Window closed after settle
    end
    m.set_odt(1'b1);
    repeat (6) @(posedge clk);
    check(32'({dqs_term_on, dq_term_on}), 32'h3); // Normal termination
    give_verdict();
  end
endmodule
